/* File: hw/occ_params.svh */
`ifndef OCC_PARAMS_SVH
`define OCC_PARAMS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define OCC_ADDR_W 8
`define OCC_DATA_W 8
`define OCC_OFS_CFG2 8'hde
`define OCC_OFS_OSC0 8'he0
`define OCC_RST_CFG2 8'h00
`define OCC_RST_OSC0 8'h02
// Writable bits; everything else reads zero, including OSC0 bit 3 (sleep_interval low bit)
`define OCC_MASK_CFG2 8'h3b
`define OCC_MASK_OSC0 8'hf7

// ----------------------------------------
// Field codes
// ----------------------------------------
`define OCC_CPU_DIV1 3'h3
`define OCC_CPU_DIV8 3'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define OCC_CLK_PERIOD_NS 50
`define OCC_BUZZ_PERIOD_NS 51200
`define OCC_BUZZ_ON_NS 1600
// Both times round down to whole cycles, with no floor at one cycle
`define OCC_BUZZ_PERIOD_CYC (`OCC_BUZZ_PERIOD_NS / `OCC_CLK_PERIOD_NS)
`define OCC_BUZZ_ON_CYC (`OCC_BUZZ_ON_NS / `OCC_CLK_PERIOD_NS)

`endif

/* File: hw/occ_pkg.sv */
package occ_pkg;

   // ----------------------------------------
   // Register bus request
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] addr;  // Byte offset
      logic [7:0] wdata; // Write data
      logic wr;          // Write strobe
      logic rd;          // Read strobe
   } occ_bus_t;

   // ----------------------------------------
   // Regulator level and clock register
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] rsv_hi;    // Reserved
      logic [2:0] reg_level; // Regulated supply code
      logic rsv_lo;          // Reserved
      logic [1:0] reg_clock; // Charge pump clock option
   } occ_cfg2_t;

   // ----------------------------------------
   // Oscillator control register
   // ----------------------------------------
   typedef struct packed {
      logic slow_clock_source_select; // 1 = external crystal
      logic buzz_disable;             // No bandgap wake in sleep
      logic keep_bandgap;             // Bandgap always on
      logic [1:0] sleep_interval;     // Sleep timer rate
      logic [2:0] cpu_speed;          // CPU clock divider code
   } occ_osc0_t;

   // ----------------------------------------
   // Whole module state
   // ----------------------------------------
   typedef struct packed {
      occ_cfg2_t cfg2;     // Regulator register
      occ_osc0_t osc0;     // Oscillator register
      logic [7:0] rdata;   // Read return
      logic slow_clk;      // Selected 32 kHz net
      logic [7:0] cpu_cnt; // Divider count
      logic cpu_tick;      // CPU clock enable
      logic [15:0] buzz_cnt; // Buzz period count
      logic bandgap_on;    // Bandgap power request
   } occ_state_t;

endpackage : occ_pkg

/* File: hw/occ_top.sv */
`timescale 1ns/1ps
`include "occ_params.svh"

module occ_top #(
   parameter int BUZZ_PERIOD = `OCC_BUZZ_PERIOD_CYC, // Buzz repeat, cycles
   parameter int BUZZ_ON = `OCC_BUZZ_ON_CYC          // Buzz width, cycles
) (
   input wire logic clk_i,                     // System clock, 20 MHz
   input wire logic resetn_i,                  // Sync reset, active low
   input wire occ_pkg::occ_bus_t bus_i,        // Register bus request
   output logic [7:0] rdata_o,                 // Read data, next cycle
   input wire logic int_slow_osc_i,            // Internal 32 kHz osc
   input wire logic external_crystal_osc_i,    // External 32 kHz crystal
   input wire logic sleep_i,                   // Device is asleep
   output logic slow_clk_o,                    // Selected 32 kHz net
   output logic [2:0] reg_level_o,             // Regulator level code
   output logic [1:0] reg_clock_o,             // Charge pump clock option
   output logic [1:0] sleep_interval_o,        // Sleep interval code
   output logic [2:0] cpu_speed_o,             // CPU speed code
   output logic cpu_tick_o,                    // CPU clock enable
   output logic bandgap_on_o                   // Bandgap power request
);

   // ----------------------------------------
   // State and next state
   // ----------------------------------------
   occ_pkg::occ_state_t st_r;   // Registered state
   occ_pkg::occ_state_t st_nxt; // Next state

   // ----------------------------------------
   // Divider terminal count
   // ----------------------------------------
   // Returns divide ratio minus one
   function automatic logic [7:0] div_last(input logic [2:0] code);
      logic [7:0] v;
      v = 8'h00;
      case (code)
         3'h0: v = 8'h07;   // Divide by 8
         3'h1: v = 8'h03;   // Divide by 4
         3'h2: v = 8'h01;   // Divide by 2
         3'h3: v = 8'h00;   // Divide by 1
         3'h4: v = 8'h0f;   // Divide by 16
         3'h5: v = 8'h1f;   // Divide by 32
         3'h6: v = 8'h7f;   // Divide by 128
         3'h7: v = 8'hff;   // Divide by 256
         default: v = 8'h00; // Unreachable for two-state codes
      endcase
      return v;
   endfunction : div_last

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // Used by both the write and read paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction : hit

   // Combinational helpers
   logic [7:0] last;      // Terminal count for current code
   logic buzz_window;     // Inside buzz on-time
   logic buzz_allowed;    // Buzz disable clear or overridden by keep

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;

      // Register writes; reserved bits forced low
      if (bus_i.wr && hit(bus_i.addr, `OCC_OFS_CFG2)) begin
         st_nxt.cfg2 = bus_i.wdata & `OCC_MASK_CFG2;
      end
      if (bus_i.wr && hit(bus_i.addr, `OCC_OFS_OSC0)) begin
         st_nxt.osc0 = bus_i.wdata & `OCC_MASK_OSC0;
      end

      // Read data stands one cycle, zero otherwise
      st_nxt.rdata = 8'h00;
      if (bus_i.rd) begin
         if (hit(bus_i.addr, `OCC_OFS_CFG2)) begin
            st_nxt.rdata = st_r.cfg2;
         end else if (hit(bus_i.addr, `OCC_OFS_OSC0)) begin
            st_nxt.rdata = st_r.osc0;
         end
      end

      // Slow clock mux; sampled, so no glitch at a switch
      if (st_r.osc0.slow_clock_source_select) begin
         st_nxt.slow_clk = external_crystal_osc_i;
      end else begin
         st_nxt.slow_clk = int_slow_osc_i;
      end

      // CPU divider; >= copes with a code that shrank
      last = div_last(st_r.osc0.cpu_speed);
      if (st_r.cpu_cnt >= last) begin
         st_nxt.cpu_cnt = 8'h00;
         st_nxt.cpu_tick = 1'b1;
      end else begin
         st_nxt.cpu_cnt = st_r.cpu_cnt + 8'h01;
         st_nxt.cpu_tick = 1'b0;
      end

      // Buzz timer runs freely; matters only in sleep
      if (st_r.buzz_cnt >= 16'(BUZZ_PERIOD - 1)) begin
         st_nxt.buzz_cnt = 16'h0000;
      end else begin
         st_nxt.buzz_cnt = st_r.buzz_cnt + 16'h0001;
      end
      buzz_window = st_r.buzz_cnt < 16'(BUZZ_ON);

      // Keep-bandgap bit outranks buzz disable
      buzz_allowed = st_r.osc0.keep_bandgap || !st_r.osc0.buzz_disable;
      if (!sleep_i) begin
         st_nxt.bandgap_on = 1'b1;       // Awake: always on
      end else if (st_r.osc0.keep_bandgap) begin
         st_nxt.bandgap_on = 1'b1;
      end else if (!buzz_allowed) begin
         st_nxt.bandgap_on = 1'b0;
      end else begin
         st_nxt.bandgap_on = buzz_window;
      end

      // Reset values; only constants taken
      if (!resetn_i) begin
         st_nxt.cfg2 = `OCC_RST_CFG2;
         st_nxt.osc0 = `OCC_RST_OSC0;
         st_nxt.rdata = 8'h00;
         st_nxt.slow_clk = 1'b0;
         st_nxt.cpu_cnt = 8'h00;
         st_nxt.cpu_tick = 1'b0;
         st_nxt.buzz_cnt = 16'h0000;
         st_nxt.bandgap_on = 1'b1;        // Powered while held in reset
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      st_r <= st_nxt;
   end

   // ----------------------------------------
   // Outputs, straight from flops
   // ----------------------------------------
   assign rdata_o = st_r.rdata;
   assign slow_clk_o = st_r.slow_clk;
   assign reg_level_o = st_r.cfg2.reg_level;
   assign reg_clock_o = st_r.cfg2.reg_clock;
   assign sleep_interval_o = st_r.osc0.sleep_interval;
   assign cpu_speed_o = st_r.osc0.cpu_speed;
   assign cpu_tick_o = st_r.cpu_tick;
   assign bandgap_on_o = st_r.bandgap_on;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   // Level code follows the written byte
   chk_level_write: assert property (
      bus_i.wr && bus_i.addr == `OCC_OFS_CFG2
      |=> reg_level_o == $past(bus_i.wdata[5:3])
   ) else $error("regulator level not written");

   // Reserved CFG2 bits never read back set
   chk_reserved_zero: assert property (
      $past(bus_i.rd) && $past(bus_i.addr) == `OCC_OFS_CFG2
      |-> (rdata_o & ~`OCC_MASK_CFG2) == 8'h00
   ) else $error("reserved bit read as one");

   // Internal oscillator reaches the net; release is seen before the flops see it
   chk_internal_select: assert property (
      resetn_i && !st_r.osc0.slow_clock_source_select
      |=> slow_clk_o == $past(int_slow_osc_i)
   ) else $error("internal oscillator not selected");

   // Crystal reaches the net
   chk_crystal_select: assert property (
      resetn_i && st_r.osc0.slow_clock_source_select
      |=> slow_clk_o == $past(external_crystal_osc_i)
   ) else $error("crystal not selected");

   // Keep bit holds bandgap through sleep
   chk_keep_wins: assert property (
      sleep_i && st_r.osc0.keep_bandgap && st_r.osc0.buzz_disable
      |=> bandgap_on_o
   ) else $error("buzz disable not ignored");

   // Disabled buzz keeps bandgap off
   chk_buzz_off: assert property (
      (sleep_i && st_r.osc0.buzz_disable && !st_r.osc0.keep_bandgap)[*2]
      |-> bandgap_on_o == 1'b0
   ) else $error("bandgap woke with buzz disabled");

   // Buzz pulse appears at period start
   chk_buzz_pulse: assert property (
      sleep_i && !st_r.osc0.keep_bandgap && !st_r.osc0.buzz_disable
      && st_r.buzz_cnt == 16'h0000
      |=> bandgap_on_o
   ) else $error("buzz pulse missing");

   // Divide by one ticks every cycle
   chk_div_one: assert property (
      (cpu_speed_o == 3'h3)[*2] |-> cpu_tick_o
   ) else $error("divide by one not ticking");

   // Divide by eight ticks eight apart
   chk_div_eight: assert property (
      (cpu_tick_o && cpu_speed_o == 3'h0) ##1 (cpu_speed_o == 3'h0)[*8]
      |-> cpu_tick_o && $past(cpu_tick_o) == 1'b0
   ) else $error("divide by eight spacing wrong");

   // Reset values after release
   chk_reset_vals: assert property (
      !$past(resetn_i) |-> cpu_speed_o == 3'h2 && reg_level_o == 3'h0
      && reg_clock_o == 2'h0 && sleep_interval_o == 2'h0
   ) else $error("reset values wrong");

   // ----------------------------------------
   // Holding and timing checks
   // ----------------------------------------

   // Reset stands in an antecedent where the next value depends on it:
   // the release edge is already seen high while the flops still reset

   // Level code holds without a write
   chk_level_hold: assert property (
      !(bus_i.wr && bus_i.addr == `OCC_OFS_CFG2)
      |=> $stable(reg_level_o)
   ) else $error("regulator level changed unwritten");

   // CPU speed code follows the written byte
   chk_speed_write: assert property (
      resetn_i && bus_i.wr && bus_i.addr == `OCC_OFS_OSC0
      |=> cpu_speed_o == $past(bus_i.wdata[2:0])
   ) else $error("cpu speed not written");

   // CPU speed code holds without a write
   chk_speed_hold: assert property (
      resetn_i && !(bus_i.wr && bus_i.addr == `OCC_OFS_OSC0)
      |=> $stable(cpu_speed_o)
   ) else $error("cpu speed changed unwritten");

   // Source select holds without a write
   chk_source_hold: assert property (
      resetn_i && !(bus_i.wr && bus_i.addr == `OCC_OFS_OSC0)
      |=> $stable(st_r.osc0.slow_clock_source_select)
   ) else $error("clock source changed unwritten");

   // Awake device keeps the bandgap up
   chk_awake_on: assert property (
      !sleep_i |=> bandgap_on_o
   ) else $error("bandgap off while awake");

   // Keep bit holds the bandgap whatever the buzz bit says
   chk_keep_on: assert property (
      sleep_i && st_r.osc0.keep_bandgap |=> bandgap_on_o
   ) else $error("bandgap off with keep set");

   // Buzz leaves the bandgap off outside its window
   chk_buzz_quiet: assert property (
      resetn_i && sleep_i && !st_r.osc0.keep_bandgap && !st_r.osc0.buzz_disable
      && st_r.buzz_cnt >= 16'(BUZZ_ON)
      |=> !bandgap_on_o
   ) else $error("bandgap on outside buzz window");

   // Divide by two ticks two apart
   chk_div_two: assert property (
      (cpu_tick_o && cpu_speed_o == 3'h2) ##1 (cpu_speed_o == 3'h2)[*2]
      |-> cpu_tick_o && $past(cpu_tick_o) == 1'b0
   ) else $error("divide by two spacing wrong");

   // Divide by four ticks four apart
   chk_div_four: assert property (
      (cpu_tick_o && cpu_speed_o == 3'h1) ##1 (cpu_speed_o == 3'h1)[*4]
      |-> cpu_tick_o && $past(cpu_tick_o) == 1'b0
   ) else $error("divide by four spacing wrong");

   // No tick right after a tick unless dividing by one
   chk_tick_single: assert property (
      cpu_tick_o && cpu_speed_o != 3'h3 |=> !cpu_tick_o
   ) else $error("tick repeated while dividing");

   // Reset leaves outputs idle and the bandgap up
   chk_reset_outs: assert property (
      !$past(resetn_i) |-> bandgap_on_o && !cpu_tick_o
      && rdata_o == 8'h00 && !slow_clk_o
   ) else $error("outputs wrong after reset");

endmodule : occ_top

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "occ_params.svh"

module tb;
   // ----------------------------------------
   // Stimulus, model and design hookup
   // ----------------------------------------
   localparam int BP = 16; // Short buzz period keeps the run brief
   localparam int BO = 4; // Short buzz width
   logic clk_i = 1'b0; // System clock
   logic resetn_i; // Sync reset, active low
   occ_pkg::occ_bus_t bus_i; // Register bus request
   logic [7:0] rdata_o; // Read data
   logic int_slow_osc_i; // Internal slow oscillator
   logic external_crystal_osc_i; // External crystal
   logic sleep_i; // Asleep flag
   logic slow_clk_o, cpu_tick_o, bandgap_on_o; // Derived nets
   logic [2:0] reg_level_o, cpu_speed_o; // Three-bit fields
   logic [1:0] reg_clock_o, sleep_interval_o; // Two-bit fields
   int bad_count = 0; // Mismatches
   int check_count = 0; // Comparisons
   int seed = 33; // Fixed random seed
   logic [7:0] cfg2_m, osc0_m; // Model registers
   logic prev_int, prev_ext; // Slow inputs as the design sampled them
   logic slow_on; // Slow clock watch enable
   int div_tab [8] = '{8, 4, 2, 1, 16, 32, 128, 256}; // Divide ratio per code

   always #25 clk_i = ~clk_i;

   occ_top #(.BUZZ_PERIOD(BP), .BUZZ_ON(BO)) u_occ_top (
      .clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o),
      .int_slow_osc_i(int_slow_osc_i), .external_crystal_osc_i(external_crystal_osc_i),
      .sleep_i(sleep_i), .slow_clk_o(slow_clk_o), .reg_level_o(reg_level_o),
      .reg_clock_o(reg_clock_o), .sleep_interval_o(sleep_interval_o),
      .cpu_speed_o(cpu_speed_o), .cpu_tick_o(cpu_tick_o), .bandgap_on_o(bandgap_on_o));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One strobe cycle, then the bus goes quiet
   task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
      @(posedge clk_i);
      bus_i <= '{addr: a, wdata: d, wr: w, rd: r};
      @(posedge clk_i);
      bus_i <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
   endtask : put

   // Write, update model, compare every field output
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      put(a, d, 1'b1, 1'b0);
      if (a == `OCC_OFS_CFG2) cfg2_m = d & `OCC_MASK_CFG2;
      if (a == `OCC_OFS_OSC0) osc0_m = d & `OCC_MASK_OSC0;
      @(negedge clk_i);
      chk(16'(reg_level_o), 16'(cfg2_m[5:3]));
      chk(16'(reg_clock_o), 16'(cfg2_m[1:0]));
      chk(16'(sleep_interval_o), 16'(osc0_m[4:3]));
      chk(16'(cpu_speed_o), 16'(osc0_m[2:0]));
   endtask : wr

   // Read; unmapped places return zero
   task automatic rd(input logic [7:0] a);
      logic [7:0] e;
      e = (a == `OCC_OFS_CFG2) ? cfg2_m : (a == `OCC_OFS_OSC0) ? osc0_m : 8'h00;
      put(a, 8'h00, 1'b0, 1'b1);
      @(negedge clk_i);
      chk(16'(rdata_o), 16'(e));
   endtask : rd

   // Count high cycles of tick and bandgap over a window
   task automatic count(input int n, output int t, output int b);
      t = 0;
      b = 0;
      repeat (n) begin
         @(negedge clk_i);
         t += (cpu_tick_o === 1'b1);
         b += (bandgap_on_o === 1'b1);
      end
   endtask : count

   task automatic results;
      if (bad_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results

   // ----------------------------------------
   // Random slow inputs and the selected-net watch
   // ----------------------------------------
   always @(posedge clk_i) begin
      prev_int = int_slow_osc_i;
      prev_ext = external_crystal_osc_i;
      int_slow_osc_i <= 1'($random(seed));
      external_crystal_osc_i <= 1'($random(seed));
   end

   // Net follows the chosen source one cycle late
   always @(negedge clk_i) begin
      if (slow_on) chk(16'(slow_clk_o), 16'(osc0_m[7] ? prev_ext : prev_int));
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      int t, b;
      bus_i = '0;
      resetn_i = 1'b0;
      sleep_i = 1'b0;
      int_slow_osc_i = 1'b0;
      external_crystal_osc_i = 1'b0;
      slow_on = 1'b0;
      cfg2_m = `OCC_RST_CFG2;
      osc0_m = `OCC_RST_OSC0;
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(negedge clk_i);
      chk(16'(cpu_speed_o), 16'h0002);
      rd(`OCC_OFS_CFG2);
      rd(`OCC_OFS_OSC0);
      // Random fields; software keeps reserved bits at zero
      repeat (8) begin
         wr(`OCC_OFS_CFG2, 8'($random(seed)) & `OCC_MASK_CFG2);
         wr(`OCC_OFS_OSC0, 8'($random(seed)) & `OCC_MASK_OSC0);
         wr(8'h55, 8'($random(seed))); // Unmapped write leaves both alone
         rd(`OCC_OFS_CFG2);
         rd(`OCC_OFS_OSC0);
         rd(8'hdf); // Unmapped read
      end
      // Both slow clock sources
      for (int s = 0; s < 2; s++) begin
         wr(`OCC_OFS_OSC0, {s[0], 7'h02});
         @(posedge clk_i);
         slow_on = 1'b1;
         repeat (40) @(posedge clk_i);
         slow_on = 1'b0;
      end
      // Every divider code; windows span whole periods
      for (int c = 0; c < 8; c++) begin
         wr(`OCC_OFS_OSC0, 8'(c));
         repeat (260) @(posedge clk_i);
         count(512, t, b);
         chk(16'(t), 16'(512 / div_tab[c]));
      end
      // Bandgap in sleep for all keep and disable pairs
      @(posedge clk_i);
      sleep_i <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         wr(`OCC_OFS_OSC0, {1'b0, k[1], k[0], 5'h02});
         repeat (2) @(posedge clk_i);
         count(2 * BP, t, b);
         chk(16'(b), 16'(k[0] ? 2 * BP : (k[1] ? 0 : 2 * BO)));
      end
      // Awake keeps the bandgap up
      @(posedge clk_i);
      sleep_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      count(2 * BP, t, b);
      chk(16'(b), 16'(2 * BP));
      // Second reset in mid-run
      @(posedge clk_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      cfg2_m = `OCC_RST_CFG2;
      osc0_m = `OCC_RST_OSC0;
      rd(`OCC_OFS_CFG2);
      rd(`OCC_OFS_OSC0);
      results();
   end
endmodule : tb
